// ---- seq_cfg_pkg.sv ----
// Constants and carrier types for the sequencer configuration bank.
// Assumes a decoded register port in front of it (serial front end elsewhere).
package seq_cfg_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register indices on the register port
  localparam logic [3:0] SEQ_MODE_CONTROL_IDX = 4'h0;
  localparam logic [3:0] READOUT_DELAY_CONTROL_IDX = 4'h1;
  localparam logic [3:0] EXPOSURE_SLOPE_CONTROL_IDX = 4'h2;
  localparam logic [3:0] WINDOW_SELECT_IDX = 4'h3;
  localparam logic [3:0] SPARE_WORD_4_IDX = 4'h4;
  localparam logic [3:0] DARK_ROW_COUNT_IDX = 4'h5;
  localparam logic [3:0] TIME_UNIT_DIVIDER_IDX = 4'h7;
  localparam logic [3:0] PERIOD_COUNT_IDX = 4'h8;

  // Reset values
  localparam logic [15:0] SEQ_MODE_CONTROL_RST = 16'h0000;
  localparam logic [15:0] READOUT_DELAY_CONTROL_RST = 16'h0000;
  localparam logic [15:0] EXPOSURE_SLOPE_CONTROL_RST = 16'h0004;
  localparam logic [15:0] WINDOW_SELECT_RST = 16'h0001;
  localparam logic [15:0] SPARE_WORD_4_RST = 16'h0000;
  localparam logic [15:0] DARK_ROW_COUNT_RST = 16'h0102;
  localparam logic [15:0] TIME_UNIT_DIVIDER_RST = 16'h0001;
  localparam logic [15:0] PERIOD_COUNT_RST = 16'h0000;

  // Writable bits; everything else is reserved and keeps its reset value
  localparam logic [15:0] SEQ_MODE_CONTROL_WMASK = 16'h3ff3;
  localparam logic [15:0] READOUT_DELAY_CONTROL_WMASK = 16'hffff;
  localparam logic [15:0] EXPOSURE_SLOPE_CONTROL_WMASK = 16'h0007;
  localparam logic [15:0] WINDOW_SELECT_WMASK = 16'h00ff;
  localparam logic [15:0] SPARE_WORD_4_WMASK = 16'h0000;
  localparam logic [15:0] DARK_ROW_COUNT_WMASK = 16'h01ff;
  localparam logic [15:0] TIME_UNIT_DIVIDER_WMASK = 16'hffff;
  localparam logic [15:0] PERIOD_COUNT_WMASK = 16'hffff;

  // Field positions in seq_mode_control
  localparam int SHUTTER_TYPE_BIT = 1;
  localparam int TRIGGERED_BIT = 4;
  localparam int SLAVE_BIT = 5;
  localparam int GAP_ENABLE_BIT = 6;
  localparam int SUBSAMPLE_BIT = 7;
  localparam int BINNING_BIT = 8;
  localparam int STATS_WINDOW_BIT = 10;
  localparam int MONITOR_LSB = 11;
  localparam int MONITOR_W = 3;

  // Field positions in readout_delay_control
  localparam int LINE_EXT_LSB = 0;
  localparam int GAP_LEN_LSB = 8;
  localparam int BYTE_W = 8;

  // Field positions in exposure_slope_control
  localparam int TWO_KNEE_BIT = 0;
  localparam int THREE_KNEE_BIT = 1;
  localparam int PERIOD_MEANING_BIT = 2;

  // Shutter type encoding
  localparam logic SHUTTER_GLOBAL = 1'b0;

  // Settings delivered to the timing engine
  typedef struct packed {
    logic rolling_shutter;
    logic triggered_exposure;
    logic slave_select;
    logic subsample_enable;
    logic binning_enable;
    logic stats_window_only;
    logic [2:0] monitor_source;
    logic [7:0] readout_gap_length;
    logic [7:0] line_extension_count;
    logic dual_slope_enable;
    logic triple_slope_enable;
    logic [15:0] reset_length;
    logic [15:0] frame_length;
    logic [7:0] window_active;
  } seq_settings_type;

endpackage

// ---- sensor_sequencer_config_regs.sv ----
// Sequencer configuration register bank with decoded settings outputs.
// Assumes the serial port front end delivers single-cycle read/write strobes.
// Reserved bits are masked on write, so they always read back their reset values.
`timescale 1ns/10ps
module sensor_sequencer_config_regs
  import seq_cfg_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output seq_settings_type settings,
  output logic gap_active,
  output logic time_unit_tick
);

  // Stored registers
  logic [15:0] seq_mode_control;
  logic [15:0] readout_delay_control;
  logic [15:0] exposure_slope_control;
  logic [15:0] window_select;
  logic [15:0] spare_word_4;
  logic [15:0] dark_row_count;
  logic [15:0] time_unit_divider;
  logic [15:0] period_count;

  // Time-unit counter
  logic [DIV_W-1:0] unit_count;

  // Address decode
  wire sel_mode = reg_addr == SEQ_MODE_CONTROL_IDX;
  wire sel_delay = reg_addr == READOUT_DELAY_CONTROL_IDX;
  wire sel_slope = reg_addr == EXPOSURE_SLOPE_CONTROL_IDX;
  wire sel_window = reg_addr == WINDOW_SELECT_IDX;
  wire sel_spare = reg_addr == SPARE_WORD_4_IDX;
  wire sel_dark = reg_addr == DARK_ROW_COUNT_IDX;
  wire sel_unit = reg_addr == TIME_UNIT_DIVIDER_IDX;
  wire sel_period = reg_addr == PERIOD_COUNT_IDX;

  // Write enables, one per mapped index
  wire wr_mode = reg_write && sel_mode;
  wire wr_delay = reg_write && sel_delay;
  wire wr_slope = reg_write && sel_slope;
  wire wr_window = reg_write && sel_window;
  wire wr_spare = reg_write && sel_spare;
  wire wr_dark = reg_write && sel_dark;
  wire wr_unit = reg_write && sel_unit;
  wire wr_period = reg_write && sel_period;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
    merge = (old & ~mask) | (reg_wdata & mask);
  endfunction

  // Next register values on a write
  wire [15:0] next_mode = wr_mode ?
                          merge(seq_mode_control, SEQ_MODE_CONTROL_WMASK) : seq_mode_control;
  wire [15:0] next_delay = wr_delay ?
                           merge(readout_delay_control, READOUT_DELAY_CONTROL_WMASK) :
                           readout_delay_control;
  wire [15:0] next_slope = wr_slope ?
                           merge(exposure_slope_control, EXPOSURE_SLOPE_CONTROL_WMASK) :
                           exposure_slope_control;
  wire [15:0] next_window = wr_window ?
                            merge(window_select, WINDOW_SELECT_WMASK) : window_select;
  wire [15:0] next_spare = wr_spare ?
                           merge(spare_word_4, SPARE_WORD_4_WMASK) : spare_word_4;
  wire [15:0] next_dark = wr_dark ?
                          merge(dark_row_count, DARK_ROW_COUNT_WMASK) : dark_row_count;
  wire [15:0] next_unit = wr_unit ?
                          merge(time_unit_divider, TIME_UNIT_DIVIDER_WMASK) : time_unit_divider;
  wire [15:0] next_period = wr_period ?
                            merge(period_count, PERIOD_COUNT_WMASK) : period_count;

  // Read mux; unmapped indices read zero
  wire [15:0] next_rdata = sel_mode ? seq_mode_control :
                           sel_delay ? readout_delay_control :
                           sel_slope ? exposure_slope_control :
                           sel_window ? window_select :
                           sel_spare ? spare_word_4 :
                           sel_dark ? dark_row_count :
                           sel_unit ? time_unit_divider :
                           sel_period ? period_count : 16'h0000;

  wire global_mode = next_mode[SHUTTER_TYPE_BIT] == SHUTTER_GLOBAL;

  // Decoded settings, taken from next values so outputs track stores
  seq_settings_type next_settings;
  always_comb begin
    next_settings = '0;
    next_settings.rolling_shutter = !global_mode;
    next_settings.triggered_exposure = global_mode && next_mode[TRIGGERED_BIT];
    next_settings.slave_select = global_mode && next_mode[SLAVE_BIT];
    next_settings.subsample_enable = next_mode[SUBSAMPLE_BIT];
    next_settings.binning_enable = next_mode[BINNING_BIT];
    next_settings.stats_window_only = next_mode[STATS_WINDOW_BIT];
    next_settings.monitor_source = next_mode[MONITOR_LSB +: MONITOR_W];
    next_settings.readout_gap_length = next_mode[GAP_ENABLE_BIT] ?
                                       next_delay[GAP_LEN_LSB +: BYTE_W] : 8'h00;
    next_settings.line_extension_count = global_mode ? 8'h00 :
                                         next_delay[LINE_EXT_LSB +: BYTE_W];
    next_settings.dual_slope_enable = global_mode && next_slope[TWO_KNEE_BIT];
    next_settings.triple_slope_enable = global_mode && next_slope[THREE_KNEE_BIT];
    next_settings.reset_length = (global_mode && !next_slope[PERIOD_MEANING_BIT]) ?
                                 next_period : 16'h0000;
    next_settings.frame_length = (global_mode && next_slope[PERIOD_MEANING_BIT]) ?
                                 next_period : 16'h0000;
    next_settings.window_active = next_window[BYTE_W-1:0];
  end

  // tick every divider periods, zero treated as one
  wire [DIV_W-1:0] unit_limit = (time_unit_divider[DIV_W-1:0] == '0) ?
                                DIV_W'(1) : time_unit_divider[DIV_W-1:0];
  wire unit_wrap = unit_count >= unit_limit - DIV_W'(1);
  wire [DIV_W-1:0] next_unit_count = unit_wrap ? '0 : unit_count + DIV_W'(1);

  // Mode and delay storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_mode_control <= SEQ_MODE_CONTROL_RST;
      readout_delay_control <= READOUT_DELAY_CONTROL_RST;
    end else begin
      seq_mode_control <= next_mode;
      readout_delay_control <= next_delay;
    end
  end

  // Slope and window storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exposure_slope_control <= EXPOSURE_SLOPE_CONTROL_RST;
      window_select <= WINDOW_SELECT_RST;
    end else begin
      exposure_slope_control <= next_slope;
      window_select <= next_window;
    end
  end

  // Spare and dark-row storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spare_word_4 <= SPARE_WORD_4_RST;
      dark_row_count <= DARK_ROW_COUNT_RST;
    end else begin
      spare_word_4 <= next_spare;
      dark_row_count <= next_dark;
    end
  end

  // Divider and period storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_unit_divider <= TIME_UNIT_DIVIDER_RST;
      period_count <= PERIOD_COUNT_RST;
    end else begin
      time_unit_divider <= next_unit;
      period_count <= next_period;
    end
  end

  // Read port: data held until the next read, valid pulsed once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : reg_rdata;
      reg_rvalid <= reg_read;
    end
  end

  // Decoded settings land at the same edge as the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settings <= '0;
      gap_active <= 1'b0;
    end else begin
      settings <= next_settings;
      gap_active <= next_mode[GAP_ENABLE_BIT];
    end
  end

  // Time-unit counter and its tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_count <= '0;
      time_unit_tick <= 1'b0;
    end else begin
      unit_count <= next_unit_count;
      time_unit_tick <= unit_wrap;
    end
  end

endmodule

// ---- seq_cfg_asserts.sv ----
// Port-level assertions for the sequencer configuration bank.
// Assumes one clock and an asynchronous active-low reset; bound below.
`timescale 1ns/10ps
module seq_cfg_checker
  import seq_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input seq_settings_type settings,
  input wire logic gap_active,
  input wire logic time_unit_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Settings follow mode writes and stay gated by shutter type or gap enable; spare word reads zero
  shutter_follow_a: assert property (
    reg_write && reg_addr == 4'h0 |=> settings.rolling_shutter == $past(reg_wdata[1]))
    else $error("shutter type did not follow write");
  gap_follow_a: assert property (
    reg_write && reg_addr == 4'h0 |=> gap_active == $past(reg_wdata[6]))
    else $error("gap enable did not follow write");
  monitor_follow_a: assert property (
    reg_write && reg_addr == 4'h0 |=> settings.monitor_source == $past(reg_wdata[13:11]))
    else $error("monitor source did not follow write");
  trig_gated_a: assert property (settings.rolling_shutter |-> !settings.triggered_exposure)
    else $error("triggered exposure active in rolling mode");
  slave_gated_a: assert property (settings.rolling_shutter |-> !settings.slave_select)
    else $error("slave select active in rolling mode");
  slope_gated_a: assert property (
    settings.rolling_shutter |-> !settings.dual_slope_enable && !settings.triple_slope_enable)
    else $error("slope enable active in rolling mode");
  gap_len_off_a: assert property (!gap_active |-> settings.readout_gap_length == 8'h00)
    else $error("gap length passed while gap disabled");
  line_ext_off_a: assert property (
    !settings.rolling_shutter |-> settings.line_extension_count == 8'h00)
    else $error("line extension passed in global mode");
  period_excl_a: assert property (
    settings.reset_length == 16'h0000 || settings.frame_length == 16'h0000)
    else $error("reset and frame length both set");
  spare_read_a: assert property (
    reg_read && reg_addr == 4'h4 |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("spare word read not zero");
endmodule
bind sensor_sequencer_config_regs seq_cfg_checker u_chk (.*);

// ---- test_sensor_sequencer_config_regs.sv ----
// Self-checking bench for the sequencer configuration bank.
// Assumes the package is compiled first; the bench drives the register port.
`timescale 1ns/10ps
module test_sensor_sequencer_config_regs;
  import seq_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid, gap_active, time_unit_tick;
  seq_settings_type settings;
  int err_count = 0, checks_done = 0, ticks;
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  sensor_sequencer_config_regs dut (.clk(clk), .rst_n(rst_n), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .settings(settings), .gap_active(gap_active),
    .time_unit_tick(time_unit_tick));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe; settings are sampled once the edge has landed
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  // One-cycle read strobe; answer is due exactly one cycle later
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk("rvalid", 16'h1, {15'h0, reg_rvalid});
    chk("rdata", exp, reg_rdata);
  endtask
  task automatic t_reset;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0004);
    rd(4'h3, 16'h0001);
    rd(4'h5, 16'h0102);
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h01ff);
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'h0000);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    chk("window", 16'h1, {8'h0, settings.window_active});
    $display("reset and reserved test done");
  endtask
  task automatic t_mode;
    wr(4'h0, 16'h2dd0);
    chk("trig", 16'h1, {15'h0, settings.triggered_exposure});
    chk("gap", 16'h1, {15'h0, gap_active});
    chk("subsample", 16'h1, {15'h0, settings.subsample_enable});
    chk("binning", 16'h1, {15'h0, settings.binning_enable});
    chk("stats", 16'h1, {15'h0, settings.stats_window_only});
    chk("monitor", 16'h5, {13'h0, settings.monitor_source});
    wr(4'h0, 16'hfff2);
    chk("trig_rolling", 16'h0, {15'h0, settings.triggered_exposure});
    chk("slave_rolling", 16'h0, {15'h0, settings.slave_select});
    rd(4'h0, 16'h3ff2);
    wr(4'h1, 16'ha55a);
    chk("gap_len", 16'h00a5, {8'h0, settings.readout_gap_length});
    chk("line_ext", 16'h005a, {8'h0, settings.line_extension_count});
    wr(4'h0, 16'h0000);
    chk("gap_off", 16'h0, {8'h0, settings.readout_gap_length});
    chk("line_global", 16'h0, {8'h0, settings.line_extension_count});
    wr(4'h0, 16'h0020);
    chk("slave", 16'h1, {15'h0, settings.slave_select});
    $display("mode and delay test done");
  endtask
  task automatic t_slope;
    wr(4'h8, 16'h1234);
    rd(4'h8, 16'h1234);
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'h0007);
    chk("dual", 16'h1, {15'h0, settings.dual_slope_enable});
    chk("triple", 16'h1, {15'h0, settings.triple_slope_enable});
    chk("frame_len", 16'h1234, settings.frame_length);
    wr(4'h0, 16'h0002);
    chk("dual_rolling", 16'h0, {15'h0, settings.dual_slope_enable});
    chk("triple_rolling", 16'h0, {15'h0, settings.triple_slope_enable});
    chk("frame_rolling", 16'h0000, settings.frame_length);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0000);
    chk("reset_len", 16'h1234, settings.reset_length);
    chk("frame_off", 16'h0000, settings.frame_length);
    wr(4'h7, 16'h0003);
    rd(4'h7, 16'h0003);
    repeat (9) @(posedge clk);
    ticks = 0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (time_unit_tick === 1'b1) ticks++;
    end
    chk("ticks", 16'h000a, 16'(ticks));
    $display("slope, period and tick test done");
  endtask
  // Mid-run reset returns the slope, divider, period and mode registers to their reset values
  task automatic t_rerun;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h2, 16'h0004);
    rd(4'h7, 16'h0001);
    rd(4'h8, 16'h0000);
    rd(4'h0, 16'h0000);
    chk("tick_unit", 16'h1, {15'h0, time_unit_tick});
    $display("mid-run reset test done");
  endtask
  // Main sequence: reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_mode;
    t_slope;
    t_rerun;
    tally_and_finish;
  end
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
endmodule
